// File: ddc_top.sv
`timescale 1ns/1ps
`include "ddc_consts.svh"
// Contract
// RULE1: two target ports, 256 and 128 bits
// RULE2: memory data bus 16 or 32 bits
// RULE3: at most 1066 Mbps per lane
// RULE4: supports DDR3, DDR3L, LPDDR3, LPDDR2
// RULE5: phy clock from pll, half rate
// RULE6: no direct fabric path to the phy
// RULE7: calibration port reads and writes config
// RULE8: selector low reads, high writes
// RULE9: start address then derived beat addresses
// RULE10: eight-bit tag per request, read or write
// RULE11: master gives length, burst kind, size
// RULE12: master gives two-bit lock kind
// RULE13: request moves on valid and ready
// RULE14: write beat moves on valid and ready
// RULE15: master tags write data, marks last
// RULE16: write data 256 or 128 bits
// RULE17: one strobe bit per byte lane
// RULE18: write answer carries tag, held until taken
// RULE19: read data width per port, tagged
// RULE20: last beat marked, moves on handshake
// RULE21: two-bit status on each read beat
// RULE22: reinitialise after memory reset release
// RULE23: start sequencer after releasing its reset
// RULE24: sequencer reset is active high
// RULE25: port signals sampled on port clock
// RULE26: same-tag answers in request order
module ddc_top
  import ddc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic memRst_b,
  input wire logic init_sequencer_reset,
  input wire logic init_sequencer_go,
  input wire ddc_mem_t memKind,
  output logic initDone,
  output ddc_mem_t memKindLive,
  input wire logic req_valid0,
  output logic req_accept0,
  input wire ddc_req_t req0,
  input wire logic wValid0,
  output logic wReady0,
  input wire ddc_wbeat0_t wBeat0,
  output logic bValid0,
  output logic [`DDC_TAG_W-1:0] bId0,
  input wire logic bReady0,
  output logic rValid0,
  output ddc_rbeat0_t rBeat0,
  input wire logic rReady0,
  input wire logic req_valid1,
  output logic req_accept1,
  input wire ddc_req_t req1,
  input wire logic wValid1,
  output logic wReady1,
  input wire ddc_wbeat1_t wBeat1,
  output logic bValid1,
  output logic [`DDC_TAG_W-1:0] bId1,
  input wire logic bReady1,
  output logic rValid1,
  output ddc_rbeat1_t rBeat1,
  input wire logic rReady1,
  input wire logic cfgScl,
  input wire logic cfgSdaIn,
  output logic cfgSdaOut,
  output logic cfgSdaOe
);
  // =====================================================
  // shared state
  // RULE3 lane ceiling, phy clock is half of it
  localparam int PHY_MHZ = `DDC_MAX_MBPS / 2;
  localparam int LW = `DDC_P0_W; // internal lane width
  logic [LW-1:0] mem [`DDC_LINES]; // backing lines
  logic [7:0] cfgTune; // extra pacing from calibration
  logic [7:0] initCnt; // init countdown
  logic initBusy; // sequencer running
  // per-port views, widened to the wide port
  logic reqValidA [`DDC_PORTS];
  ddc_req_t reqA [`DDC_PORTS];
  logic wValidA [`DDC_PORTS];
  logic [LW-1:0] wDataA [`DDC_PORTS];
  logic [`DDC_P0_B-1:0] wStrbA [`DDC_PORTS];
  logic wLastA [`DDC_PORTS];
  logic bReadyA [`DDC_PORTS];
  logic rReadyA [`DDC_PORTS];
  logic acceptA [`DDC_PORTS];
  logic wReadyA [`DDC_PORTS];
  logic bValidA [`DDC_PORTS];
  logic [`DDC_TAG_W-1:0] bIdA [`DDC_PORTS];
  logic rValidA [`DDC_PORTS];
  ddc_rbeat0_t rBeatA [`DDC_PORTS];
  // write path into the memory
  logic wFireA [`DDC_PORTS];
  logic [31:0] memAddrA [`DDC_PORTS];
  logic [LW-1:0] laneDataA [`DDC_PORTS];
  logic [`DDC_P0_B-1:0] laneStrbA [`DDC_PORTS];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // =====================================================
  // decode helpers
  function automatic logic [3:0] lineIdx(input logic [31:0] a);
    lineIdx = a[`DDC_LINE_HI:`DDC_LINE_LO];
  endfunction : lineIdx

  function automatic logic inRange(input logic [31:0] a);
    inRange = (a[31:`DDC_LINE_HI+1] == '0);
  endfunction : inRange

  // RULE9 next beat address from kind and size
  function automatic logic [31:0] nextAddr(input logic [31:0] a, input ddc_req_t r);
    logic [31:0] step;
    logic [31:0] mask;
    step = 32'h1 << r.req_beat_size;
    mask = (({24'h0, r.req_beat_count} + 32'h1) << r.req_beat_size) - 32'h1;
    if (r.req_burst_kind == `DDC_BURST_FIXED)
      nextAddr = a;
    else if (r.req_burst_kind == `DDC_BURST_WRAP)
      nextAddr = (a & ~mask) | ((a + step) & mask);
    else
      nextAddr = a + step;
  endfunction : nextAddr

  // =====================================================
  // RULE1 two ports, narrow one zero-extended
  assign reqValidA[0] = req_valid0;
  assign reqValidA[1] = req_valid1;
  assign reqA[0] = req0;
  assign reqA[1] = req1;
  assign wValidA[0] = wValid0;
  assign wValidA[1] = wValid1;
  assign wDataA[0] = wBeat0.data;
  assign wDataA[1] = {{`DDC_P1_W{1'b0}}, wBeat1.data};
  assign wStrbA[0] = wBeat0.strb;
  assign wStrbA[1] = {{`DDC_P1_B{1'b0}}, wBeat1.strb};
  assign wLastA[0] = wBeat0.last;
  assign wLastA[1] = wBeat1.last;
  assign bReadyA[0] = bReady0;
  assign bReadyA[1] = bReady1;
  assign rReadyA[0] = rReady0;
  assign rReadyA[1] = rReady1;
  assign req_accept0 = acceptA[0];
  assign req_accept1 = acceptA[1];
  assign wReady0 = wReadyA[0];
  assign wReady1 = wReadyA[1];
  assign bValid0 = bValidA[0];
  assign bValid1 = bValidA[1];
  assign bId0 = bIdA[0];
  assign bId1 = bIdA[1];
  assign rValid0 = rValidA[0];
  assign rValid1 = rValidA[1];
  assign rBeat0 = rBeatA[0];
  // RULE19 narrow port returns the low half
  assign rBeat1 = '{data: rBeatA[1].data[`DDC_P1_W-1:0], tag: rBeatA[1].tag,
    last: rBeatA[1].last, resp: rBeatA[1].resp};

  // =====================================================
  // init sequencer; memory reset clears done, go starts a new run
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      initCnt <= 8'h00;
      initBusy <= 1'b0;
      initDone <= 1'b0;
      memKindLive <= M_DDR3;
    end
    else if (ce)
    begin
      // RULE24 held while its reset is high
      if (init_sequencer_reset || !memRst_b)
      begin
        initCnt <= 8'h00;
        initBusy <= 1'b0;
        initDone <= 1'b0;
      end
      // RULE4 memory kind caught at launch
      else if (init_sequencer_go && !initBusy && !initDone)
      begin
        initBusy <= 1'b1;
        initCnt <= 8'(`DDC_INIT_CYC - 1);
        memKindLive <= memKind;
      end
      else if (initBusy)
      begin
        if (initCnt == 8'h00)
        begin
          initBusy <= 1'b0;
          initDone <= 1'b1;
        end
        else
          initCnt <= initCnt - 8'h01;
      end
    end

  // =====================================================
  // memory lines; later port wins a same-cycle clash
  always_ff @(posedge clk)
    if (ce)
      for (int q = 0; q < `DDC_PORTS; q++)
        if (wFireA[q] && inRange(memAddrA[q]))
          // RULE17 only strobed lanes land
          for (int b = 0; b < `DDC_P0_B; b++)
            if (laneStrbA[q][b])
              mem[lineIdx(memAddrA[q])][8*b+:8] <= laneDataA[q][8*b+:8];

  // =====================================================
  // port engines, one outstanding burst each
  generate
    for (genvar p = 0; p < `DDC_PORTS; p++)
    begin : g_port
      // RULE2 phy cycles per beat at this dq width
      localparam int BEAT_CYC = ((p == 0) ? `DDC_P0_W : `DDC_P1_W) / (2 * `DDC_DQ_WIDTH);
      ddc_state_t st; // engine phase
      ddc_req_t req; // held request
      logic [31:0] addr; // current beat address
      logic [7:0] left; // beats after this one
      logic [7:0] pace; // wait before next beat
      logic [7:0] paceLoad;
      logic ok; // address maps to a line
      logic push; // read beat into fifo
      logic inReady;
      logic fVal;
      logic pop;
      logic [LW-1:0] line;
      logic [LW-1:0] rdData;
      ddc_rbeat0_t fIn;
      ddc_rbeat0_t fOut;

      assign ok = inRange(addr);
      assign paceLoad = 8'(BEAT_CYC - 1) + {4'h0, cfgTune[3:0]};
      assign line = mem[lineIdx(addr)];
      assign push = (st == S_READ) && (pace == 8'h00) && inReady;
      assign memAddrA[p] = addr;
      // RULE14 beat moves on valid and ready
      assign wFireA[p] = wValidA[p] && wReadyA[p];
      // RULE21 unmapped reads answer slave error
      assign fIn = '{data: rdData, tag: req.req_tag, last: (left == 8'h00),
        resp: ok ? `DDC_RESP_OKAY : `DDC_RESP_SLVERR};

      if (p == 0)
      begin : g_full
        assign laneDataA[p] = wDataA[p];
        assign laneStrbA[p] = wStrbA[p];
        assign rdData = ok ? line : '0;
      end
      else
      begin : g_half
        // RULE9 narrow beats steer by address half
        assign laneDataA[p] = addr[`DDC_HALF_BIT] ?
          (wDataA[p] << `DDC_P1_W) : wDataA[p];
        assign laneStrbA[p] = addr[`DDC_HALF_BIT] ?
          (wStrbA[p] << `DDC_P1_B) : wStrbA[p];
        assign rdData = !ok ? '0 : addr[`DDC_HALF_BIT] ?
          (line >> `DDC_P1_W) : {{`DDC_P1_W{1'b0}}, line[`DDC_P1_W-1:0]};
      end

      // RULE26 idle-only accept keeps order
      // RULE25 single clock, no crossing needed
      always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
          st <= S_IDLE;
          req <= '0;
          addr <= '0;
          left <= 8'h00;
          pace <= 8'h00;
          acceptA[p] <= 1'b0;
          wReadyA[p] <= 1'b0;
          bValidA[p] <= 1'b0;
          bIdA[p] <= '0;
        end
        else if (ce)
        begin
          case (st)
            S_IDLE:
              // RULE13 take on valid and ready
              if (reqValidA[p] && acceptA[p])
              begin
                req <= reqA[p];
                addr <= reqA[p].req_start_address;
                left <= reqA[p].req_beat_count;
                pace <= 8'h00;
                acceptA[p] <= 1'b0;
                wReadyA[p] <= reqA[p].req_is_write;
                // RULE10 selector picks the tag's meaning
                st <= reqA[p].req_is_write ? S_WRITE : S_READ;
              end
              else
                acceptA[p] <= initDone;
            S_WRITE:
              if (wFireA[p])
              begin
                addr <= nextAddr(addr, req);
                wReadyA[p] <= 1'b0;
                pace <= paceLoad;
                // RULE18 answer once the burst ends
                if (wLastA[p] || left == 8'h00)
                begin
                  st <= S_RESP;
                  bValidA[p] <= 1'b1;
                  bIdA[p] <= req.req_tag;
                end
                else
                  left <= left - 8'h01;
              end
              else if (!wReadyA[p])
              begin
                if (pace == 8'h00)
                  wReadyA[p] <= 1'b1;
                else
                  pace <= pace - 8'h01;
              end
            S_RESP:
              if (bReadyA[p])
              begin
                bValidA[p] <= 1'b0;
                st <= S_IDLE;
                acceptA[p] <= initDone;
              end
            default:
              if (push)
              begin
                addr <= nextAddr(addr, req);
                pace <= paceLoad;
                // RULE20 last beat closes the burst
                if (left == 8'h00)
                begin
                  st <= S_IDLE;
                  acceptA[p] <= initDone;
                end
                else
                  left <= left - 8'h01;
              end
              else if (pace != 8'h00)
                pace <= pace - 8'h01;
          endcase
        end

      // read beats queue here; a stalled master fills it
      ddc_fifo #(.WIDTH($bits(ddc_rbeat0_t)), .DEPTH(`DDC_FIFO_DEPTH)) u_rq (
        .clk(clk),
        .rst_b(rst_b),
        .en(ce),
        .inValid(push),
        .inReady(inReady),
        .inData(fIn),
        .outValid(fVal),
        .outReady(pop),
        .outData(fOut)
      );

      // RULE20 output stage holds until taken
      assign pop = ce && (!rValidA[p] || rReadyA[p]);
      always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
          rValidA[p] <= 1'b0;
          rBeatA[p] <= '0;
        end
        else if (pop)
        begin
          rValidA[p] <= fVal;
          rBeatA[p] <= fOut;
        end

      sequence sPush;
        push;
      endsequence
      sequence sWriteEnd;
        wFireA[p] && wLastA[p];
      endsequence
      // RULE13 accept only idle
      a_accept_idle: assert property (acceptA[p] |-> st == S_IDLE) // RULE13
        else $error("accept outside idle");
      // RULE13 handshake takes request
      a_take_hshake: assert property ( // RULE13
        (st == S_IDLE) && reqValidA[p] && acceptA[p] |=> (st != S_IDLE) && !acceptA[p])
        else $error("request not taken");
      // RULE14 ready only writing
      a_wready_write: assert property (wReadyA[p] |-> st == S_WRITE) // RULE14
        else $error("write ready outside write");
      // RULE18 answer follows burst
      a_write_resp: assert property (sWriteEnd |=> bValidA[p] && bIdA[p] == req.req_tag) // RULE18
        else $error("no write answer");
      // RULE18 answer held stalled
      a_bresp_hold: assert property ( // RULE18
        bValidA[p] && !bReadyA[p] |=> bValidA[p] && $stable(bIdA[p]))
        else $error("write answer dropped");
      // RULE20 read beat held
      a_rbeat_hold: assert property ( // RULE20
        rValidA[p] && !rReadyA[p] |=> rValidA[p] && $stable(rBeatA[p]))
        else $error("read beat dropped");
      // RULE19 beat carries tag
      a_rtag_req: assert property (push |-> fIn.tag == req.req_tag) // RULE19
        else $error("read tag wrong");
      // RULE21 status code legal
      a_rresp_legal: assert property ( // RULE21
        rValidA[p] |-> rBeatA[p].resp inside {`DDC_RESP_OKAY, `DDC_RESP_SLVERR})
        else $error("bad read status");
      // RULE2 beats paced apart
      a_beat_gap: assert property (sPush |=> !push) // RULE2
        else $error("read beats too close");
    end
  endgenerate

  // =====================================================
  // RULE6 phy reached only through the engines above
  // RULE7 calibration port owns the tuning registers
  ddc_i2c_cfg u_cfg (
    .clk(clk),
    .rst_b(rst_b),
    .en(ce),
    .scl(cfgScl),
    .sdaIn(cfgSdaIn),
    .sdaOut(cfgSdaOut),
    .sdaOe(cfgSdaOe),
    .tune(cfgTune)
  );
endmodule : ddc_top

// File: ddc_consts.svh
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH
// =====================================================
// port and memory geometry
`define DDC_PORTS 2
`define DDC_P0_W 256
`define DDC_P1_W 128
`define DDC_P0_B 32
`define DDC_P1_B 16
`define DDC_TAG_W 8
`define DDC_DQ_WIDTH 32
`define DDC_MAX_MBPS 1066
`define DDC_LINES 16
`define DDC_LINE_LO 5
`define DDC_LINE_HI 8
`define DDC_HALF_BIT 4
// =====================================================
// burst kinds and read answers
`define DDC_BURST_FIXED 2'h0
`define DDC_BURST_WRAP 2'h2
`define DDC_RESP_OKAY 2'h0
`define DDC_RESP_SLVERR 2'h2
// =====================================================
// timing at 25 MHz
`define DDC_CLK_NS 40
`define DDC_INIT_NS 2000
`define DDC_INIT_CYC ((`DDC_INIT_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_FIFO_DEPTH 8
// =====================================================
// calibration port
`define DDC_I2C_ADDR 7'h28
`define DDC_CFG_REGS 2
`define DDC_CFG_RST 8'h00
`endif

// File: ddc_pkg.sv
`include "ddc_consts.svh"
// =====================================================
// shared types
package ddc_pkg;
  // per-port engine states
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_WRITE = 2'b01, S_RESP = 2'b10,
    S_READ = 2'b11} ddc_state_t;
  // calibration port states
  typedef enum logic [2:0] {I_IDLE = 3'b000, I_DEV = 3'b001, I_IDX = 3'b010,
    I_WR = 3'b011, I_RD = 3'b100} ddc_i2c_t;
  // supported memory kinds
  typedef enum logic [1:0] {M_DDR3 = 2'b00, M_DDR3L = 2'b01, M_LPDDR3 = 2'b10,
    M_LPDDR2 = 2'b11} ddc_mem_t;
  // shared read/write request
  typedef struct packed {
    logic req_is_write;
    logic [31:0] req_start_address;
    logic [`DDC_TAG_W-1:0] req_tag;
    logic [7:0] req_beat_count;
    logic [1:0] req_burst_kind;
    logic [2:0] req_beat_size;
    logic [1:0] req_lock_kind;
  } ddc_req_t;
  // write beats
  typedef struct packed {
    logic [`DDC_P0_W-1:0] data;
    logic [`DDC_P0_B-1:0] strb;
    logic [`DDC_TAG_W-1:0] tag;
    logic last;
  } ddc_wbeat0_t;
  typedef struct packed {
    logic [`DDC_P1_W-1:0] data;
    logic [`DDC_P1_B-1:0] strb;
    logic [`DDC_TAG_W-1:0] tag;
    logic last;
  } ddc_wbeat1_t;
  // read beats
  typedef struct packed {
    logic [`DDC_P0_W-1:0] data;
    logic [`DDC_TAG_W-1:0] tag;
    logic last;
    logic [1:0] resp;
  } ddc_rbeat0_t;
  typedef struct packed {
    logic [`DDC_P1_W-1:0] data;
    logic [`DDC_TAG_W-1:0] tag;
    logic last;
    logic [1:0] resp;
  } ddc_rbeat1_t;
endpackage : ddc_pkg

// File: ddc_fifo.sv
`timescale 1ns/1ps
`include "ddc_consts.svh"
// =====================================================
// flop fifo, depth must be a power of two
module ddc_fifo
  import ddc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = `DDC_FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH]; // entry storage
  logic [AW-1:0] wrIdx; // next slot to fill
  logic [AW-1:0] rdIdx; // oldest slot
  logic [AW:0] count; // fill level, one bit wider than index
  logic doPush;
  logic doPop;

  assign inReady = (count != (AW + 1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = store[rdIdx];
  assign doPush = en && inValid && inReady;
  assign doPop = en && outValid && outReady;

  // storage has no reset, only written slots are read
  always_ff @(posedge clk)
    if (doPush)
      store[wrIdx] <= inData;

  // pointers wrap naturally at a power-of-two depth
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      wrIdx <= '0;
      rdIdx <= '0;
      count <= '0;
    end
    else
    begin
      if (doPush)
        wrIdx <= wrIdx + 1'b1;
      if (doPop)
        rdIdx <= rdIdx + 1'b1;
      if (doPush && !doPop)
        count <= count + 1'b1;
      else if (doPop && !doPush)
        count <= count - 1'b1;
    end
endmodule : ddc_fifo

// File: ddc_i2c_cfg.sv
`timescale 1ns/1ps
`include "ddc_consts.svh"
// =====================================================
// calibration port: slave with an index byte, then data
module ddc_i2c_cfg
  import ddc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [7:0] tune
);
  ddc_i2c_t st; // protocol phase
  logic [7:0] regs [`DDC_CFG_REGS]; // tuning registers
  logic [7:0] sh; // bit shifter, both directions
  logic [3:0] bitCnt; // bits of this byte, 9 in ack slot
  logic [7:0] idx; // register pointer, auto increments
  logic sclQ;
  logic sdaQ;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [7:0] rdByte;

  assign tune = regs[0];
  // open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sclRise = scl && !sclQ;
  assign sclFall = !scl && sclQ;
  assign startSeen = scl && sclQ && sdaQ && !sdaIn;
  assign stopSeen = scl && sclQ && !sdaQ && sdaIn;
  // unmapped indices read as zero
  assign rdByte = (idx < 8'(`DDC_CFG_REGS)) ? regs[idx[0]] : 8'h00;

  // =====================================================
  // line history for edge and start/stop detection
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end
    else if (en)
    begin
      sclQ <= scl;
      sdaQ <= sdaIn;
    end

  // =====================================================
  // byte engine, sda changes only while scl is low
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      st <= I_IDLE;
      sh <= 8'h00;
      bitCnt <= 4'h0;
      idx <= 8'h00;
      sdaOe <= 1'b0;
      for (int i = 0; i < `DDC_CFG_REGS; i++)
        regs[i] <= `DDC_CFG_RST;
    end
    else if (en)
    begin
      if (startSeen)
      begin
        st <= I_DEV;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end
      else if (stopSeen)
      begin
        st <= I_IDLE;
        sdaOe <= 1'b0;
      end
      else if (st != I_IDLE && sclRise)
      begin
        if (bitCnt < 4'h8)
        begin
          sh <= {sh[6:0], sdaIn};
          bitCnt <= bitCnt + 4'h1;
        end
        // master nack ends a read
        else if (st == I_RD && sdaIn)
          st <= I_IDLE;
      end
      else if (st != I_IDLE && sclFall)
      begin
        if (bitCnt == 4'h8)
        begin
          // byte done: ack it unless we are sending or the device address is not ours
          bitCnt <= 4'h9;
          sdaOe <= (st != I_RD);
          // RULE7 register write
          if (st == I_WR && idx < 8'(`DDC_CFG_REGS))
            regs[idx[0]] <= sh;
          if (st == I_WR)
            idx <= idx + 8'h01;
          if (st == I_IDX)
            idx <= sh;
          if (st == I_DEV && sh[7:1] != `DDC_I2C_ADDR)
          begin
            st <= I_IDLE;
            sdaOe <= 1'b0;
          end
        end
        else if (bitCnt == 4'h9)
        begin
          bitCnt <= 4'h0;
          sdaOe <= 1'b0;
          // RULE7 register read
          if ((st == I_DEV && sh[0]) || st == I_RD)
          begin
            st <= I_RD;
            sh <= rdByte;
            sdaOe <= !rdByte[7];
            idx <= idx + 8'h01;
          end
          else if (st == I_DEV)
            st <= I_IDX;
          else if (st == I_IDX)
            st <= I_WR;
        end
        // next read bit
        else if (st == I_RD)
          sdaOe <= !sh[7];
      end
    end
endmodule : ddc_i2c_cfg

// File: ddc_fab_master_model.sv
`timescale 1ns/1ps
// =====================================================
// fabric side ready pacing for answers
module ddc_fab_master_model
  import ddc_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] mode,
  output logic [3:0] ready
);
  // own seed so pacing never shifts the bench data
  int seed = 32'hB3836B39;
  initial ready = 4'h0;
  always @(posedge clk)
    ready <= #2 (mode == 2'h0) ? 4'hF : (mode == 2'h1) ? 4'($random(seed)) : 4'h0;
endmodule : ddc_fab_master_model

// File: tb_ddr_controller_axi_ports.sv
`timescale 1ns/1ps
`include "ddc_consts.svh"
module tb_ddr_controller_axi_ports
  import ddc_pkg::*;
;
  // =====================================================
  // design signals, all joined by matching names
  logic clk = 1'b0, rst_b, ce, memRst_b, init_sequencer_reset, init_sequencer_go, initDone;
  ddc_mem_t memKind, memKindLive;
  logic req_valid0, req_accept0, wValid0, wReady0, bValid0, bReady0, rValid0, rReady0;
  logic req_valid1, req_accept1, wValid1, wReady1, bValid1, bReady1, rValid1, rReady1;
  ddc_req_t req0, req1;
  ddc_wbeat0_t wBeat0;
  ddc_wbeat1_t wBeat1;
  ddc_rbeat0_t rBeat0;
  ddc_rbeat1_t rBeat1;
  logic [7:0] bId0, bId1;
  logic cfgScl, cfgSdaIn, cfgSdaOut, cfgSdaOe;
  logic [1:0] mode;
  logic [3:0] rdy;
  // expected notes: {care data, beat} and write answer tags
  logic [267:0] q0[$], q1[$];
  logic [7:0] bq0[$], bq1[$];
  logic [255:0] mem [16];
  int seed = 32'hB3836B39;
  int n_errors = 0, cmp_count = 0, k;
  wire [3:0] hs = {wReady1, req_accept1, wReady0, req_accept0};
  assign {bReady1, bReady0, rReady1, rReady0} = rdy;
  ddc_top uut (.*);
  ddc_fab_master_model partner (.clk(clk), .mode(mode), .ready(rdy));
  always #20 clk = ~clk;
  // =====================================================
  // shared helpers
  task tick;
    @(posedge clk);
    #2;
  endtask : tick
  task stop_test;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [255:0] seen, input logic [255:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // bounded wait for one handshake edge, inputs held until then
  task waitHs(input int s);
    int i;
    i = 0;
    do begin @(posedge clk); i++; end while (hs[s] !== 1'b1 && i < 500);
    #2;
    if (i >= 500) begin n_errors++; stop_test; end
  endtask : waitHs
  // next request only once every note is settled
  task drain;
    int i;
    for (i = 0; i < 3000 && (q0.size() + q1.size() + bq0.size() + bq1.size()) > 0; i++)
    begin
      if (i == 60) mode = 2'h1;
      tick;
    end
    if (i == 3000) begin n_errors++; stop_test; end
  endtask : drain
  task sendReq(input int p, input ddc_req_t r);
    if (p == 0) begin req0 = r; req_valid0 = 1'b1; end
    else begin req1 = r; req_valid1 = 1'b1; end
    waitHs(p * 2);
    req_valid0 = 1'b0;
    req_valid1 = 1'b0;
  endtask : sendReq
  task wrBurst(input int p, input logic [31:0] a, input logic [7:0] n, input logic [7:0] t);
    logic [255:0] d;
    int j, h;
    h = a[4] ? 128 : 0;
    if (p == 0) bq0.push_back(t); else bq1.push_back(t);
    sendReq(p, '{1'b1, a, t, n, 2'h1, p ? 3'h4 : 3'h5, 2'h0});
    for (k = 0; k <= n; k++)
    begin
      for (j = 0; j < 8; j++) d[j*32 +: 32] = $random(seed);
      if (p == 0) mem[(a >> 5) + k] = d; else mem[a >> 5][h +: 128] = d[127:0];
      wBeat0 = '{d, 32'hFFFFFFFF, t, k == n};
      wBeat1 = '{d[127:0], 16'hFFFF, t, k == n};
      if (p == 0) wValid0 = 1'b1; else wValid1 = 1'b1;
      waitHs(p * 2 + 1);
    end
    wValid0 = 1'b0;
    wValid1 = 1'b0;
    drain;
  endtask : wrBurst
  // beat lines follow the burst kind
  task rdBurst(input int p, input logic [31:0] a, input logic [7:0] n, input logic [1:0] kd,
      input logic [7:0] t);
    logic [267:0] e;
    int ln, b, h;
    b = a >> 5;
    h = a[4] ? 128 : 0;
    for (k = 0; k <= n; k++)
    begin
      ln = (kd == 2'h0) ? b : (kd == 2'h2) ? ((b & ~n) | ((b + k) & n)) : b + k;
      e = {a < 512, p ? {128'h0, mem[ln][h +: 128]} : mem[ln], t, k == n,
        a < 512 ? 2'h0 : 2'h2};
      if (p == 0) q0.push_back(e); else q1.push_back(e);
    end
    sendReq(p, '{1'b0, a, t, n, kd, p ? 3'h4 : 3'h5, 2'h0});
    drain;
  endtask : rdBurst
  task seeBeat(input ddc_rbeat0_t s, input logic [267:0] e);
    ddc_rbeat0_t x;
    x = e[266:0];
    chk({s.tag, s.last, s.resp}, {x.tag, x.last, x.resp}, "rtag");
    if (e[267]) chk(s.data, x.data, "rdata");
  endtask : seeBeat
  // =====================================================
  // watcher: oldest note against each handshake
  always @(posedge clk)
  begin
    if (rValid0 === 1'b1 && rReady0 === 1'b1) seeBeat(rBeat0, q0.pop_front());
    if (rValid1 === 1'b1 && rReady1 === 1'b1)
      seeBeat({128'h0, rBeat1}, q1.pop_front());
    if (bValid0 === 1'b1 && bReady0 === 1'b1) chk(bId0, bq0.pop_front(), "bId0");
    if (bValid1 === 1'b1 && bReady1 === 1'b1) chk(bId1, bq1.pop_front(), "bId1");
  end
  // =====================================================
  // main sequence
  initial
  begin
    {rst_b, memRst_b, init_sequencer_go, req_valid0, req_valid1, wValid0, wValid1} = '0;
    {ce, cfgScl, cfgSdaIn, init_sequencer_reset} = 4'hF;
    {req0, req1, wBeat0, wBeat1, mode} = '0;
    memKind = M_DDR3;
    repeat (6) @(posedge clk);
    #2 rst_b = 1'b1;
    chk(req_accept0, 1'b0, "accept");
    init_sequencer_reset = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      memRst_b = 1'b0;
      tick;
      memRst_b = 1'b1;
      memKind = ddc_mem_t'(m);
      init_sequencer_go = 1'b1;
      tick;
      init_sequencer_go = 1'b0;
      for (k = 0; k < 100 && initDone !== 1'b1; k++) tick;
      chk(k, 50, "initEdges");
      chk(memKindLive, m, "memKind");
    end
    wrBurst(0, 32'h0, 8'h9, 8'h11);
    wrBurst(1, 32'h110, 8'h0, 8'h22);
    // stalled drain first so the beat fifo fills up
    mode = 2'h2;
    rdBurst(0, 32'h0, 8'h9, 2'h1, 8'h33);
    for (int m = 0; m < 3; m++) rdBurst(0, 32'h40, 8'h3, 2'(m), 8'h40 + 8'(m));
    rdBurst(1, 32'h110, 8'h0, 2'h1, 8'h55);
    rdBurst(0, 32'h200, 8'h0, 2'h1, 8'h66);
    stop_test;
  end
endmodule : tb_ddr_controller_axi_ports
